/* src/rtcca_pkg.sv */
package rtcca_pkg;
    // ------------------------------------------------------------
    // clock source selection
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RTCCA_SRC_XTAL = 2'h0,
        RTCCA_SRC_LSRC = 2'h1,
        RTCCA_SRC_HSDV = 2'h2
    } rtcca_src_t;

    // ------------------------------------------------------------
    // widths, reset values and counts
    // ------------------------------------------------------------
    localparam int          RTCCA_CNT_W      = 32;
    localparam int          RTCCA_PRE_W      = 20;
    localparam int          RTCCA_HSE_DIV    = 128;
    localparam int          RTCCA_HSE_DIV_W  = 7;
    localparam int          RTCCA_XTAL_HZ    = 32768;
    localparam int          RTCCA_CAL_HZ     = 512;
    // a 32.768 kHz source divided by 32768 gives one tick per second
    localparam logic [19:0] RTCCA_PRE_RST    = 20'h07FFF;
    // 32768 / 512 = 64 source cycles per calibration period
    localparam int          RTCCA_CAL_DIV    = RTCCA_XTAL_HZ / RTCCA_CAL_HZ;
    localparam logic [5:0]  RTCCA_CAL_HALF   = 6'h1F;
endpackage

/* src/rtcca_src_sel.sv */
module rtcca_src_sel (
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_i,
    input  wire rtcca_pkg::rtcca_src_t src_sel_i,
    input  wire logic                  xtal_en_i,
    input  wire logic                  lsrc_en_i,
    input  wire logic                  hse_en_i,
    output logic                       src_en_o
);
    import rtcca_pkg::*;

    // last count of the fixed divider, where one pulse passes
    localparam logic [RTCCA_HSE_DIV_W-1:0] HSE_LAST =
        RTCCA_HSE_DIV_W'(RTCCA_HSE_DIV - 1);

    // ------------------------------------------------------------
    // high-speed source, fixed divide by 128
    // ------------------------------------------------------------
    logic [RTCCA_HSE_DIV_W-1:0] hse_cnt_r;
    logic                       hse_div_en;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            hse_cnt_r <= 7'h00;
        end else if (hse_en_i) begin
            hse_cnt_r <= hse_cnt_r + 7'h01;
        end
    end

    assign hse_div_en = hse_en_i && (hse_cnt_r == HSE_LAST);

    // ------------------------------------------------------------
    // source mux
    // ------------------------------------------------------------
    always_comb begin
        case (src_sel_i)
            RTCCA_SRC_XTAL: src_en_o = xtal_en_i;
            RTCCA_SRC_LSRC: src_en_o = lsrc_en_i;
            RTCCA_SRC_HSDV: src_en_o = hse_div_en;
            default:        src_en_o = 1'b0;
        endcase
    end

    AST_HSE_WRAP: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        hse_div_en |=> hse_cnt_r == '0)
        else $error("high-speed divider did not wrap");

    AST_HSE_HOLD: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        !hse_en_i |=> $stable(hse_cnt_r))
        else $error("high-speed divider moved without a pulse");
endmodule

/* src/rtcca_top.sv */
module rtcca_top #(
    parameter int CNT_W = rtcca_pkg::RTCCA_CNT_W,
    parameter int PRE_W = rtcca_pkg::RTCCA_PRE_W
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_i,
    input  wire rtcca_pkg::rtcca_src_t src_sel_i,
    input  wire logic                  xtal_en_i,
    input  wire logic                  lsrc_en_i,
    input  wire logic                  hse_en_i,
    input  wire logic                  pre_load_i,
    input  wire logic [PRE_W-1:0]      pre_val_i,
    input  wire logic                  cnt_load_i,
    input  wire logic [CNT_W-1:0]      cnt_val_i,
    input  wire logic [CNT_W-1:0]      cmp_val_i,
    input  wire logic                  cal_en_i,
    output logic [CNT_W-1:0]           cnt_o,
    output logic                       tick_o,
    output logic                       alarm_o,
    output logic                       cal_clk_o
);
    import rtcca_pkg::*;

    logic                 src_en;
    logic [PRE_W-1:0]     pre_reload_r;
    logic [PRE_W-1:0]     pre_cnt_r;
    logic                 wrap;
    logic [5:0]           cal_cnt_r;

    // ------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------
    rtcca_src_sel u_src (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .src_sel_i (src_sel_i),
        .xtal_en_i (xtal_en_i),
        .lsrc_en_i (lsrc_en_i),
        .hse_en_i  (hse_en_i),
        .src_en_o  (src_en)
    );

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pre_reload_r <= PRE_W'(RTCCA_PRE_RST);
        end else if (pre_load_i) begin
            pre_reload_r <= pre_val_i;
        end
    end

    assign wrap = src_en && (pre_cnt_r == '0);

    // a new reload takes effect at the next wrap, so the running
    // second is never cut short by a reload write
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pre_cnt_r <= PRE_W'(RTCCA_PRE_RST);
        end else if (wrap) begin
            pre_cnt_r <= pre_reload_r;
        end else if (src_en) begin
            pre_cnt_r <= pre_cnt_r - PRE_W'(1'h1);
        end
    end

    // ------------------------------------------------------------
    // counter, tick and alarm
    // ------------------------------------------------------------
    // the count rolls from all ones to zero with no carry out
    // a load wins over a tick in the same cycle
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cnt_o <= '0;
        end else if (cnt_load_i) begin
            cnt_o <= cnt_val_i;
        end else if (wrap) begin
            cnt_o <= cnt_o + CNT_W'(1'h1);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            tick_o <= 1'b0;
        end else begin
            tick_o <= wrap;
        end
    end

    // alarm fires once, as the counter steps onto the compare value
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            alarm_o <= 1'b0;
        end else begin
            alarm_o <= !cnt_load_i && wrap
                       && ((cnt_o + CNT_W'(1'h1)) == cmp_val_i);
        end
    end

    // ------------------------------------------------------------
    // calibration clock
    // ------------------------------------------------------------
    // only 512 Hz when the source is a true 32.768 kHz crystal
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !cal_en_i) begin
            cal_cnt_r <= 6'h00;
            cal_clk_o <= 1'b0;
        end else if (src_en) begin
            cal_cnt_r <= cal_cnt_r + 6'h01;
            if (cal_cnt_r == RTCCA_CAL_HALF || cal_cnt_r == 6'h3F) begin
                cal_clk_o <= !cal_clk_o;
            end
        end
    end

    // ------------------------------------------------------------
    // check helpers
    // ------------------------------------------------------------
    // counts source pulses upward, apart from the down-counter, so a
    // slip in the prescaler shows as a period of the wrong length
    logic [PRE_W:0]       chk_pulses_r;
    logic [PRE_W-1:0]     chk_len_r;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            chk_pulses_r <= '0;
            chk_len_r    <= PRE_W'(RTCCA_PRE_RST);
        end else if (wrap) begin
            chk_pulses_r <= '0;
            chk_len_r    <= pre_reload_r;
        end else if (src_en) begin
            chk_pulses_r <= chk_pulses_r + (PRE_W+1)'(1'h1);
        end
    end

    // ------------------------------------------------------------
    // checks: counter and alarm
    // ------------------------------------------------------------
    AST_RST_OUT: assert property (
        @(posedge ref_clk_i)
        rst_i |=> cnt_o == '0 && !tick_o && !alarm_o && !cal_clk_o)
        else $error("outputs not cleared by reset");

    AST_CNT_LOAD: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        cnt_load_i |=> cnt_o == $past(cnt_val_i))
        else $error("counter did not take loaded value");

    AST_CNT_HOLD: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        !cnt_load_i && !wrap |=> $stable(cnt_o))
        else $error("counter moved without tick or load");

    AST_ALARM: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        alarm_o |-> cnt_o == $past(cmp_val_i))
        else $error("alarm without compare match");

    AST_ALARM_STEP: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        wrap && !cnt_load_i |=> alarm_o == (cnt_o == $past(cmp_val_i)))
        else $error("alarm does not follow the step onto compare");

    AST_ALARM_LOAD: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        cnt_load_i |=> !alarm_o)
        else $error("alarm raised by a counter load");

    AST_TICK_INC: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        wrap && !cnt_load_i |=> tick_o
            && cnt_o == $past(cnt_o) + CNT_W'(1'h1))
        else $error("wrap did not tick and increment");

    AST_TICK_CAUSE: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        tick_o |-> $past(src_en) && $past(pre_cnt_r) == '0)
        else $error("tick without wrap");

    AST_CLASH_TICK: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        cnt_load_i && wrap |=> tick_o && !alarm_o)
        else $error("tick lost when a load met a wrap");

    // ------------------------------------------------------------
    // checks: prescaler, source and calibration
    // ------------------------------------------------------------
    AST_RST_PRE: assert property (
        @(posedge ref_clk_i)
        rst_i |=> pre_reload_r == PRE_W'(RTCCA_PRE_RST))
        else $error("prescaler reset value wrong");

    AST_PRE_LOAD: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        pre_load_i |=> pre_reload_r == $past(pre_val_i))
        else $error("prescaler reload value not stored");

    AST_PRE_HOLD: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        !src_en |=> $stable(pre_cnt_r))
        else $error("prescaler moved without source pulse");

    AST_PRE_RELOAD: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        wrap |=> pre_cnt_r == $past(pre_reload_r))
        else $error("prescaler did not reload");

    AST_PERIOD: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        wrap |-> chk_pulses_r == {1'b0, chk_len_r})
        else $error("tick period differs from reload");

    AST_SRC_NONE: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        src_sel_i == rtcca_src_t'(2'h3) |-> !src_en)
        else $error("source pulse with no source selected");

    AST_HSE_PICK: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        src_sel_i == RTCCA_SRC_HSDV && src_en |-> hse_en_i)
        else $error("divided source pulse without a high-speed pulse");

    AST_CAL_OFF: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        !cal_en_i |=> !cal_clk_o)
        else $error("calibration clock while disabled");

    AST_CAL_STEP: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        $changed(cal_clk_o) |-> $past(src_en) || !$past(cal_en_i))
        else $error("calibration clock moved without a source pulse");
endmodule

/* dv/tb_rtc_counter_alarm.sv */
module tb_rtc_counter_alarm;
    timeunit 1ns;
    timeprecision 1ns;
    import rtcca_pkg::*;
    // ------------------------------------------------------------
    // stimulus, outputs and counters
    // ------------------------------------------------------------
    logic        ref_clk_i  = 1'b0;
    logic        rst_i      = 1'b1;
    rtcca_src_t  src_sel_i  = RTCCA_SRC_XTAL;
    logic [2:0]  en_r       = 3'h0;
    logic        pre_load_i = 1'b0;
    logic [19:0] pre_val_i  = 20'h00000;
    logic        cnt_load_i = 1'b0;
    logic [31:0] cnt_val_i  = 32'h0;
    logic [31:0] cmp_val_i  = 32'h0;
    logic        cal_en_i   = 1'b0;
    logic        cal_q      = 1'b0;
    logic [31:0] cnt_o;
    logic        tick_o;
    logic        alarm_o;
    logic        cal_clk_o;
    int          failures   = 0;
    int          checks     = 0;
    int          ticks      = 0;
    int          alarms     = 0;
    int          flips      = 0;

    rtcca_top i_dut (
        .ref_clk_i  (ref_clk_i),
        .rst_i      (rst_i),
        .src_sel_i  (src_sel_i),
        .xtal_en_i  (en_r[0]),
        .lsrc_en_i  (en_r[1]),
        .hse_en_i   (en_r[2]),
        .pre_load_i (pre_load_i),
        .pre_val_i  (pre_val_i),
        .cnt_load_i (cnt_load_i),
        .cnt_val_i  (cnt_val_i),
        .cmp_val_i  (cmp_val_i),
        .cal_en_i   (cal_en_i),
        .cnt_o      (cnt_o),
        .tick_o     (tick_o),
        .alarm_o    (alarm_o),
        .cal_clk_o  (cal_clk_o)
    );

    always #50 ref_clk_i = ~ref_clk_i;

    // events counted mid-cycle, where every output has settled
    always @(negedge ref_clk_i) begin
        ticks  += int'(tick_o === 1'b1);
        alarms += int'(alarm_o === 1'b1);
        flips  += int'(cal_clk_o !== cal_q);
        cal_q  = cal_clk_o;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // n one-cycle pulses on source enable w, then let results land
    task automatic run(input int w, input int n);
        repeat (n) begin
            @(posedge ref_clk_i);
            en_r <= 3'(1 << w);
        end
        @(posedge ref_clk_i);
        en_r <= 3'h0;
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
    endtask

    task automatic load(input logic [31:0] v, input logic [31:0] c);
        @(posedge ref_clk_i);
        cnt_val_i  <= v;
        cmp_val_i  <= c;
        cnt_load_i <= 1'b1;
        @(posedge ref_clk_i);
        cnt_load_i <= 1'b0;
        @(negedge ref_clk_i);
    endtask

    task automatic test_done;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_base;
        ticks = 0;
        @(posedge ref_clk_i);
        pre_val_i  <= 20'h00003;
        pre_load_i <= 1'b1;
        @(posedge ref_clk_i);
        pre_load_i <= 1'b0;
        run(0, 32767);
        chk(32'(ticks), 32'h0);
        run(0, 1);
        chk(32'(ticks), 32'h1);
        chk(cnt_o, 32'h1);
        run(0, 8);
        chk(32'(ticks), 32'h3);
        run(0, 3);
        chk(32'(ticks), 32'h3);
        run(0, 1);
        chk(cnt_o, 32'h4);
        $display("test base done");
    endtask

    // wrap through all ones onto zero; a load onto the compare is silent
    task automatic t_alarm;
        alarms = 0;
        load(32'h0, 32'h0);
        chk(32'(alarms), 32'h0);
        load(32'hFFFFFFFE, 32'h0);
        run(0, 4);
        chk(cnt_o, 32'hFFFFFFFF);
        chk(32'(alarms), 32'h0);
        run(0, 4);
        chk(cnt_o, 32'h0);
        chk(32'(alarms), 32'h1);
        $display("test alarm done");
    endtask

    // a load landing on a wrap wins; the tick still fires, the alarm not
    task automatic t_clash;
        ticks  = 0;
        alarms = 0;
        run(0, 3);
        @(posedge ref_clk_i);
        cnt_val_i  <= 32'h00000010;
        cmp_val_i  <= 32'h00000001;
        cnt_load_i <= 1'b1;
        en_r       <= 3'h1;
        @(posedge ref_clk_i);
        cnt_load_i <= 1'b0;
        en_r       <= 3'h0;
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk(cnt_o, 32'h00000010);
        chk(32'(ticks), 32'h1);
        chk(32'(alarms), 32'h0);
        $display("test clash done");
    endtask

    task automatic t_src;
        ticks = 0;
        @(posedge ref_clk_i);
        src_sel_i <= RTCCA_SRC_LSRC;
        run(0, 8);
        chk(32'(ticks), 32'h0);
        run(1, 4);
        chk(32'(ticks), 32'h1);
        @(posedge ref_clk_i);
        src_sel_i <= RTCCA_SRC_HSDV;
        run(2, 4 * RTCCA_HSE_DIV - 1);
        chk(32'(ticks), 32'h1);
        run(2, 1);
        chk(32'(ticks), 32'h2);
        @(posedge ref_clk_i);
        src_sel_i <= rtcca_src_t'(2'h3);
        run(0, 8);
        run(1, 8);
        chk(32'(ticks), 32'h2);
        @(posedge ref_clk_i);
        src_sel_i <= RTCCA_SRC_XTAL;
        $display("test source done");
    endtask

    // half period of the calibration clock is 32 source pulses
    task automatic t_cal;
        @(posedge ref_clk_i);
        cal_en_i <= 1'b1;
        @(negedge ref_clk_i);
        flips = 0;
        run(0, 31);
        chk(32'(flips), 32'h0);
        run(0, 1);
        chk(32'(flips), 32'h1);
        run(0, 64);
        chk(32'(flips), 32'h3);
        @(posedge ref_clk_i);
        cal_en_i <= 1'b0;
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk(32'(cal_clk_o), 32'h0);
        $display("test calibration done");
    endtask

    initial begin
        repeat (11) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk(32'({tick_o, alarm_o, cal_clk_o}), 32'h0);
        chk(cnt_o, 32'h0);
        @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_base();
        t_alarm();
        t_clash();
        t_src();
        t_cal();
        test_done();
    end

    // about 34000 cycles are needed; allow half as much again
    initial begin
        #5000000;
        failures++;
        test_done();
    end
endmodule
